// [src/wfs_top.sv]
`timescale 1ns/1ps
`default_nettype none
module wfs_top
  import wfs_pkg::*;
#(
  parameter int WAKE_FILT = wfs_pkg::WAKE_FILT_CYC,
  parameter int CLAMP_T = wfs_pkg::CLAMP_CYC,
  parameter int UVDET_T = wfs_pkg::UVDET_CYC,
  parameter int UVREC_T = wfs_pkg::UVREC_CYC,
  parameter int ENIDLE_T = wfs_pkg::ENIDLE_CYC,
  parameter int WPAT_T = wfs_pkg::WPAT_CYC
) (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic MODE_SELECT,
  input wire logic LOW_POWER_SELECT_N,
  input wire logic TRANSMIT_GATE_N,
  input wire logic GUARDIAN_GATE,
  input wire logic TX_DATA,
  input wire logic BUS_RX_DATA,
  input wire logic BUS_IDLE,
  input wire logic LOCAL_WAKE_IN,
  input wire logic BAT_BELOW,
  input wire logic CORE_BELOW,
  input wire logic IO_BELOW,
  input wire logic TEMP_WARN,
  input wire logic TEMP_SHUTDOWN,
  input wire logic BUS_PATTERN_OK,
  output logic DIAG_SERIAL_OUT,
  output logic REGULATOR_CONTROL_OUTPUT,
  output logic RX_DATA_OUT,
  output logic RECEIVE_ACTIVITY_N,
  output logic TX_ENABLE,
  output logic WAKE_PULL_UP,
  output logic ERROR_SUMMARY,
  output logic [2:0] MODE_STATE
);
  import wfs_pkg::*;

  wfs_mode_e mode_q, mode_d;
  logic en_i, low_power_select_n_i, transmit_gate_n_n_i, bge_i, txd_i;
  logic lwake_f, uvcc_raw, uvio_raw, uvcc_rec;
  logic lwake_q, rwake_q, wake_q, power_on_flag_q, twarn_q, otemp_q, clamp_q;
  logic buserr_q, uvbat_q, uvcc_q, uvio_q;
  logic lwake_p, rwake_p, low_power_select_n_p, uvbat_p, en_p, transmit_gate_n_p;
  logic [STAT_W-1:0] sticky_q, shift_q;
  logic [3:0] bitcnt_q;
  logic reading_q;
  logic [31:0] idle_q, clamp_cnt_q, wpat_q, gap_q;
  logic low_pw, norm_pw, enter_low, enter_norm, uv_set, bus_wake;
  logic [STAT_W-1:0] flags_now;
  logic rd_edge;

  assign en_i = IO_BELOW ? 1'b0 : MODE_SELECT;
  assign low_power_select_n_i = IO_BELOW ? 1'b0 : LOW_POWER_SELECT_N;
  assign txd_i = IO_BELOW ? 1'b0 : TX_DATA;
  assign bge_i = IO_BELOW ? 1'b0 : GUARDIAN_GATE;
  assign transmit_gate_n_n_i = IO_BELOW ? 1'b1 : TRANSMIT_GATE_N;

  wfs_filter #(.LIMIT(WAKE_FILT)) u_lwake (
    .clk(CORE_CLK), .rst_n(RST_N), .din(~LOCAL_WAKE_IN), .dout(lwake_f));
  wfs_filter #(.LIMIT(UVDET_T)) u_uvcc (
    .clk(CORE_CLK), .rst_n(RST_N), .din(CORE_BELOW), .dout(uvcc_raw));
  wfs_filter #(.LIMIT(UVREC_T)) u_ccrec (
    .clk(CORE_CLK), .rst_n(RST_N), .din(~CORE_BELOW), .dout(uvcc_rec));
  wfs_filter #(.LIMIT(UVDET_T)) u_uvio (
    .clk(CORE_CLK), .rst_n(RST_N), .din(IO_BELOW), .dout(uvio_raw));
  assign WAKE_PULL_UP = ~lwake_f;

  assign low_pw = (mode_q == MD_STANDBY) || (mode_q == MD_GOSLEEP) ||
                  (mode_q == MD_SLEEP);
  assign norm_pw = !low_pw;
  assign enter_low = (mode_d != mode_q) && (mode_d == MD_STANDBY ||
                     mode_d == MD_GOSLEEP || mode_d == MD_SLEEP) &&
                     norm_pw;
  assign enter_norm = (mode_d == MD_NORMAL) && (mode_q != MD_NORMAL);
  assign uv_set = (BAT_BELOW && !uvbat_q) || (uvcc_raw && !uvcc_q) ||
                  (uvio_raw && IO_BELOW && !uvio_q);
  // read edge only from the real pin while io present
  assign rd_edge = !IO_BELOW && (MODE_SELECT != en_p);

  // bus wake pattern, tolerates short breaks
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      wpat_q <= 32'h0;
      gap_q <= 32'h0;
    end
    else if (BUS_PATTERN_OK)
    begin
      gap_q <= 32'h0;
      if (wpat_q < 32'(WPAT_T))
        wpat_q <= wpat_q + 32'h1;
    end
    else if (gap_q < 32'(BSS_GAP_CYC))
      gap_q <= gap_q + 32'h1;
    else
      wpat_q <= 32'h0;
  end
  assign bus_wake = (wpat_q == 32'(WPAT_T - 1)) && BUS_PATTERN_OK;

  always_comb
  begin
    mode_d = mode_q;
    if (uvbat_q || uvio_q)
      mode_d = MD_SLEEP;
    else if (uvcc_q)
      mode_d = MD_STANDBY;
    else if (mode_q == MD_SLEEP && !wake_q && !low_power_select_n_i)
      mode_d = MD_SLEEP;
    else if (low_power_select_n_i)
      mode_d = en_i ? MD_NORMAL : MD_RXONLY;
    else
      mode_d = en_i ? MD_GOSLEEP : MD_STANDBY;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      mode_q <= MD_SLEEP;
    else
      mode_q <= mode_d;
  end

  // edge history
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      lwake_p <= 1'b0;
      rwake_p <= 1'b0;
      low_power_select_n_p <= 1'b0;
      uvbat_p <= 1'b0;
      en_p <= 1'b0;
      transmit_gate_n_p <= 1'b1;
    end
    else
    begin
      lwake_p <= lwake_q;
      rwake_p <= rwake_q;
      low_power_select_n_p <= low_power_select_n_i;
      uvbat_p <= uvbat_q;
      en_p <= MODE_SELECT;
      transmit_gate_n_p <= transmit_gate_n_n_i;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      lwake_q <= 1'b0;
      rwake_q <= 1'b0;
    end
    else
    begin
      if (low_pw && lwake_f)
        lwake_q <= 1'b1;
      else if (enter_low)
        lwake_q <= 1'b0;
      if (low_pw && bus_wake && !BAT_BELOW)
        rwake_q <= 1'b1;
      else if (enter_low)
        rwake_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      wake_q <= 1'b0;
    else if ((lwake_q && !lwake_p) || (rwake_q && !rwake_p) ||
             (low_power_select_n_i && !low_power_select_n_p && !IO_BELOW) || (!uvbat_q && uvbat_p))
      wake_q <= 1'b1;
    else if (enter_norm || enter_low || uv_set)
      wake_q <= 1'b0;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      uvbat_q <= 1'b0;
      uvcc_q <= 1'b0;
      uvio_q <= 1'b0;
    end
    else
    begin
      uvbat_q <= BAT_BELOW && !(wake_q && uvbat_q);
      if (uvcc_raw && !uvcc_q)
        uvcc_q <= 1'b1;
      else if (uvcc_rec || wake_q)
        uvcc_q <= 1'b0;
      if (uvio_raw && IO_BELOW && !uvio_q)
        uvio_q <= 1'b1;
      else if (!IO_BELOW || wake_q)
        uvio_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      power_on_flag_q <= 1'b1;
    else if (enter_norm)
      power_on_flag_q <= 1'b0;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      twarn_q <= 1'b0;
      otemp_q <= 1'b0;
    end
    else if (!BAT_BELOW)
    begin
      if (norm_pw && TEMP_WARN)
        twarn_q <= 1'b1;
      else if (norm_pw && !TEMP_WARN)
        twarn_q <= 1'b0;
      else if (low_pw && reading_q && idle_q == 32'(ENIDLE_T - 1))
        twarn_q <= 1'b0;
      if (norm_pw && TEMP_SHUTDOWN)
        otemp_q <= 1'b1;
      else if (norm_pw && !transmit_gate_n_n_i && transmit_gate_n_p)
        otemp_q <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      clamp_cnt_q <= 32'h0;
      clamp_q <= 1'b0;
    end
    else if (transmit_gate_n_n_i || !bge_i)
    begin
      clamp_cnt_q <= 32'h0;
      clamp_q <= 1'b0;
    end
    else if (clamp_cnt_q >= 32'(CLAMP_T - 1))
      clamp_q <= 1'b1;
    else
      clamp_cnt_q <= clamp_cnt_q + 32'h1;
  end

  assign TX_ENABLE = (mode_q == MD_NORMAL) && !transmit_gate_n_n_i && bge_i &&
                     !otemp_q && !clamp_q;

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
      buserr_q <= 1'b0;
    else if (!TX_ENABLE || BUS_RX_DATA == txd_i)
      buserr_q <= 1'b0;
    else if (!BUS_PATTERN_OK && !BUS_IDLE)
      buserr_q <= 1'b1;
  end

  always_comb
  begin
    flags_now = '0;
    flags_now[S_LWAKE] = lwake_q;
    flags_now[S_RWAKE] = rwake_q;
    flags_now[S_FIXED] = 1'b1;
    flags_now[S_POWER_ON_FLAG] = power_on_flag_q;
    flags_now[S_BUSERR] = buserr_q;
    flags_now[S_OTEMP] = otemp_q;
    flags_now[S_TWARN] = twarn_q;
    flags_now[S_CLAMP] = clamp_q;
    flags_now[S_UVBAT] = uvbat_q;
    flags_now[S_UVCC] = uvcc_q;
    flags_now[S_UVIO] = uvio_q;
  end

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sticky_q <= STAT_RST;
      idle_q <= 32'h0;
      reading_q <= 1'b0;
    end
    else
    begin
      if (rd_edge)
      begin
        idle_q <= 32'h0;
        reading_q <= 1'b1;
      end
      else if (reading_q && idle_q == 32'(ENIDLE_T - 1))
      begin
        reading_q <= 1'b0;
        idle_q <= 32'h0;
      end
      else if (reading_q)
        idle_q <= idle_q + 32'h1;
      if (reading_q && !rd_edge && idle_q == 32'(ENIDLE_T - 1))
        sticky_q <= (sticky_q & {4'h0, {9{1'b1}}} & 13'h000F) | flags_now;
      else
        sticky_q <= (sticky_q | flags_now) & 13'h07FF;
    end
  end

  assign ERROR_SUMMARY = |sticky_q[S_UVIO:S_BUSERR];

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      shift_q <= STAT_RST;
      bitcnt_q <= 4'h0;
      DIAG_SERIAL_OUT <= 1'b1;
    end
    else if (rd_edge)
    begin
      if (!reading_q)
      begin
        shift_q <= {2'b00, sticky_q[S_UVIO:S_POWER_ON_FLAG], flags_now[2:0]} >> 1;
        DIAG_SERIAL_OUT <= ~flags_now[S_LWAKE];
        bitcnt_q <= 4'h1;
      end
      else if (bitcnt_q < 4'(STAT_W))
      begin
        DIAG_SERIAL_OUT <= ~shift_q[0];
        shift_q <= shift_q >> 1;
        bitcnt_q <= bitcnt_q + 4'h1;
      end
      else
        DIAG_SERIAL_OUT <= 1'b1;
    end
    else if (!reading_q)
      DIAG_SERIAL_OUT <= ~ERROR_SUMMARY;
  end

  assign REGULATOR_CONTROL_OUTPUT = (mode_q != MD_SLEEP);
  assign RX_DATA_OUT = low_pw ? !wake_q : BUS_RX_DATA;
  assign RECEIVE_ACTIVITY_N = low_pw ? !wake_q : BUS_IDLE;
  assign MODE_STATE = mode_q;

  chk_bat_sleep: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    uvbat_q |=> mode_q == MD_SLEEP && !REGULATOR_CONTROL_OUTPUT)
    else $error("battery low not in sleep");
  chk_cc_standby: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    uvcc_q && !uvbat_q && !uvio_q |=> mode_q == MD_STANDBY)
    else $error("core low not in standby");
  chk_otemp_tx: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    otemp_q |-> !TX_ENABLE) else $error("tx on while hot");
  chk_clamp_tx: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    clamp_q |-> !TX_ENABLE) else $error("tx on while clamped");
  chk_err_sum: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    (buserr_q || otemp_q || twarn_q || clamp_q || uvbat_q || uvcc_q ||
     uvio_q) |=> ERROR_SUMMARY)
    else $error("summary missing");
  chk_rx_wake: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    low_pw && wake_q |-> !RX_DATA_OUT && !RECEIVE_ACTIVITY_N)
    else $error("rx not low on wake");
  chk_low_power_select_n_wake: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    $rose(low_power_select_n_i) && !IO_BELOW |=> wake_q) else $error("no wake on edge");
  chk_s11_zero: assert property (
    @(posedge CORE_CLK) disable iff (!RST_N)
    sticky_q[12:11] == 2'b00 && sticky_q[S_FIXED])
    else $error("fixed bits wrong");
  cov_sleep: cover property (@(posedge CORE_CLK) mode_q == MD_SLEEP);
  cov_read: cover property (@(posedge CORE_CLK) bitcnt_q == 4'(STAT_W));
  cov_clamp: cover property (@(posedge CORE_CLK) $rose(clamp_q));
endmodule
`default_nettype wire

// [src/wfs_pkg.sv]
package wfs_pkg;
  // status layout
  localparam int STAT_W = 13;
  localparam int S_LWAKE = 0;
  localparam int S_RWAKE = 1;
  localparam int S_FIXED = 2;
  localparam int S_POWER_ON_FLAG = 3;
  localparam int S_BUSERR = 4;
  localparam int S_OTEMP = 5;
  localparam int S_TWARN = 6;
  localparam int S_CLAMP = 7;
  localparam int S_UVBAT = 8;
  localparam int S_UVCC = 9;
  localparam int S_UVIO = 10;
  localparam logic [STAT_W-1:0] STAT_RST = 13'h0004;
  // timing, ns and cycles at 250 MHz
  localparam int CLK_NS = 4;
  localparam int BSS_GAP_NS = 130;
  localparam int BSS_GAP_CYC = (BSS_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_FILT_NS = 50000;
  localparam int WAKE_FILT_CYC = WAKE_FILT_NS / CLK_NS;
  localparam int CLAMP_NS = 2600000;
  localparam int CLAMP_CYC = CLAMP_NS / CLK_NS;
  localparam int UVDET_NS = 100000;
  localparam int UVDET_CYC = UVDET_NS / CLK_NS;
  localparam int UVREC_NS = 1000000;
  localparam int UVREC_CYC = UVREC_NS / CLK_NS;
  localparam int ENIDLE_NS = 100000;
  localparam int ENIDLE_CYC = ENIDLE_NS / CLK_NS;
  localparam int WPAT_NS = 6000;
  localparam int WPAT_CYC = WPAT_NS / CLK_NS;
  typedef enum logic [2:0] {
    MD_NORMAL, MD_RXONLY, MD_STANDBY, MD_GOSLEEP, MD_SLEEP
  } wfs_mode_e;
endpackage

// [src/wfs_filter.sv]
`timescale 1ns/1ps
`default_nettype none
// level must hold for LIMIT cycles before output follows
module wfs_filter #(
  parameter int LIMIT = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic [31:0] cnt_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 32'h0;
      dout <= 1'b0;
    end
    else if (din == dout)
      cnt_q <= 32'h0;
    else if (cnt_q >= 32'(LIMIT - 1))
    begin
      cnt_q <= 32'h0;
      dout <= din;
    end
    else
      cnt_q <= cnt_q + 32'h1;
  end
endmodule
`default_nettype wire

// [tb/wfs_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// host side: mode pin driver and serial status reader
module wfs_host_model
  import wfs_pkg::*;
#(
  parameter int IDLE = 8
) (
  input wire logic clk,
  input wire logic diag,
  output logic en
);
  initial en = 1'b1;
  task automatic set_en(input logic v);
    @(posedge clk);
    en <= v;
  endtask
  // called only with supplies in range
  task automatic read_status(output logic [STAT_W-1:0] bits);
    int i;
    for (i = 0; i < STAT_W + 1; i++)
    begin
      @(posedge clk);
      en <= ~en;
      repeat (2) @(posedge clk);
      #1;
      if (i < STAT_W)
        bits[i] = ~diag;
    end
    // even toggle count restores pin level
    repeat (IDLE + 4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wfs_pkg::*;
  localparam int FT = 8;
  localparam int CT = 16;
  logic clk, rst_n, lps_n, gate_n, guard, tx_d, rx_b, lwake;
  logic bat_lo, core_lo, io_lo, t_warn, t_shut, bus_ok;
  logic en, diag, reg_on, rxd_o, rxa_n, tx_en, pull_up, err_sum;
  logic [2:0] mode;
  logic [STAT_W-1:0] st;
  int mismatches = 0;
  int tests_run = 0;
  wfs_top #(.WAKE_FILT(FT), .CLAMP_T(CT), .UVDET_T(FT), .UVREC_T(FT),
    .ENIDLE_T(FT), .WPAT_T(FT)) dut (
    .CORE_CLK(clk), .RST_N(rst_n), .MODE_SELECT(en),
    .LOW_POWER_SELECT_N(lps_n), .TRANSMIT_GATE_N(gate_n),
    .GUARDIAN_GATE(guard), .TX_DATA(tx_d), .BUS_RX_DATA(rx_b),
    .BUS_IDLE(1'b0), .LOCAL_WAKE_IN(lwake), .BAT_BELOW(bat_lo),
    .CORE_BELOW(core_lo), .IO_BELOW(io_lo), .TEMP_WARN(t_warn),
    .TEMP_SHUTDOWN(t_shut), .BUS_PATTERN_OK(bus_ok),
    .DIAG_SERIAL_OUT(diag), .REGULATOR_CONTROL_OUTPUT(reg_on),
    .RX_DATA_OUT(rxd_o), .RECEIVE_ACTIVITY_N(rxa_n), .TX_ENABLE(tx_en),
    .WAKE_PULL_UP(pull_up), .ERROR_SUMMARY(err_sum), .MODE_STATE(mode));
  wfs_host_model #(.IDLE(FT)) host (.clk(clk), .diag(diag), .en(en));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic regate();
    @(posedge clk);
    gate_n <= 1'b1;
    cyc(2);
    @(posedge clk);
    gate_n <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_start();
    check(mode, MD_SLEEP);
    check(reg_on, 1'b0);
    check(diag, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    cyc(FT + 4);
    check(pull_up, 1'b1);
    @(posedge clk);
    lps_n <= 1'b1;
    cyc(4);
    check(mode, MD_NORMAL);
    check(reg_on, 1'b1);
    host.read_status(st);
    check(st[2:0], 3'b100);
    check(st[12:4], 9'h000);
  endtask
  task automatic t_supply();
    logic [2:0] md [3];
    int s;
    md = '{MD_SLEEP, MD_STANDBY, MD_SLEEP};
    for (s = 0; s < 3; s++)
    begin
      @(posedge clk);
      {io_lo, core_lo, bat_lo} <= 3'b001 << s;
      cyc(3 * FT);
      check(mode, md[s]);
      check(reg_on, s == 1);
      check(err_sum, 1'b1);
      check(diag, 1'b0);
      @(posedge clk);
      {io_lo, core_lo, bat_lo} <= 3'b000;
      cyc(3 * FT);
      check(mode, MD_NORMAL);
      host.read_status(st);
      check(st[S_UVBAT + s], 1'b1);
      check(err_sum, 1'b0);
      check(diag, 1'b1);
    end
  endtask
  task automatic t_clamp();
    @(posedge clk);
    gate_n <= 1'b0;
    guard <= 1'b1;
    cyc(3);
    check(tx_en, 1'b1);
    cyc(CT + 4);
    check(tx_en, 1'b0);
    check(err_sum, 1'b1);
    regate();
    cyc(3);
    check(tx_en, 1'b1);
    @(posedge clk);
    gate_n <= 1'b1;
    host.read_status(st);
    check(st[S_CLAMP], 1'b1);
    check(err_sum, 1'b0);
  endtask
  task automatic t_temp();
    @(posedge clk);
    t_shut <= 1'b1;
    t_warn <= 1'b1;
    gate_n <= 1'b0;
    cyc(4);
    check(tx_en, 1'b0);
    @(posedge clk);
    t_shut <= 1'b0;
    t_warn <= 1'b0;
    cyc(3);
    check(tx_en, 1'b0);
    regate();
    cyc(3);
    check(tx_en, 1'b1);
    @(posedge clk);
    gate_n <= 1'b1;
    host.read_status(st);
    check(st[S_TWARN:S_OTEMP], 2'b11);
    check(err_sum, 1'b0);
  endtask
  task automatic t_buserr();
    @(posedge clk);
    gate_n <= 1'b0;
    rx_b <= 1'b0;
    cyc(4);
    check(err_sum, 1'b1);
    check(tx_en, 1'b1);
    @(posedge clk);
    rx_b <= 1'b1;
    gate_n <= 1'b1;
    host.read_status(st);
    check(st[S_BUSERR], 1'b1);
    check(err_sum, 1'b0);
  endtask
  task automatic t_lwake();
    host.set_en(1'b0);
    lps_n <= 1'b0;
    cyc(4);
    check(mode, MD_STANDBY);
    check({rxd_o, rxa_n}, 2'b11);
    @(posedge clk);
    lwake <= 1'b0;
    cyc(FT + 4);
    check(pull_up, 1'b0);
    check({rxd_o, rxa_n}, 2'b00);
    host.read_status(st);
    check(st[1:0], 2'b01);
    @(posedge clk);
    lwake <= 1'b1;
    cyc(FT + 4);
    check(pull_up, 1'b1);
  endtask
  // bus wake pattern in low power
  task automatic t_bwake();
    @(posedge clk);
    bus_ok <= 1'b1;
    cyc(4);
    @(posedge clk);
    bus_ok <= 1'b0;
    cyc(40);
    @(posedge clk);
    bus_ok <= 1'b1;
    cyc(4);
    @(posedge clk);
    bus_ok <= 1'b0;
    cyc(40);
    host.read_status(st);
    check(st[S_RWAKE], 1'b0);
    @(posedge clk);
    bus_ok <= 1'b1;
    cyc(4);
    @(posedge clk);
    bus_ok <= 1'b0;
    cyc(2);
    @(posedge clk);
    bus_ok <= 1'b1;
    cyc(8);
    @(posedge clk);
    bus_ok <= 1'b0;
    host.read_status(st);
    check(st[1:0], 2'b11);
  endtask
  initial
  begin
    rst_n = 1'b0;
    lps_n = 1'b0;
    gate_n = 1'b1;
    guard = 1'b0;
    tx_d = 1'b1;
    rx_b = 1'b1;
    lwake = 1'b1;
    bat_lo = 1'b0;
    core_lo = 1'b0;
    io_lo = 1'b0;
    t_warn = 1'b0;
    t_shut = 1'b0;
    bus_ok = 1'b0;
    cyc(4);
    t_start();
    t_supply();
    t_clamp();
    t_temp();
    t_buserr();
    t_lwake();
    t_bwake();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
